/* File: include/gpio_map.vh */
// Register indices, field positions and reset values of the GPIO block
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_EDGE_SELECT 6'h0c
`define IDX_A_INPUT_EN 6'h0d
`define IDX_B_INPUT_EN 6'h0e
`define IDX_C_INPUT_EN 6'h0f
`define IDX_A_DATA 6'h10
`define IDX_A_DIR 6'h11
`define IDX_A_PULLUP 6'h12
`define IDX_B_DATA 6'h13
`define IDX_B_DIR 6'h14
`define IDX_B_PULLUP 6'h15
`define IDX_IRQ_STATUS 6'h30
`define IDX_IRQ_MASK 6'h31
`define IDX_GROUP_SELECT 6'h32

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PORT 8'h00
`define RST_INPUT_EN 8'hff
`define RST_EDGE 5'h00
`define RST_IRQ 3'h0
`define RST_GROUP 4'h0

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define EDGE_TIMER_BIT 4
`define EDGE_G1_HI 3
`define EDGE_G1_LO 2
`define EDGE_G0_HI 1
`define EDGE_G0_LO 0
`define EDGE_BOTH 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define IRQ_G0 0
`define IRQ_G1 1
`define IRQ_TIMER 2
`define OPEN_DRAIN_BIT 5

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;

  // ----------------------------------------------------------------
  // Sync chain
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ----------------------------------------------------------------
  // Level follows once stages two and three agree
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
          level[i] <= 1'b0;
        else if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
    end
  endgenerate
endmodule

/* File: hdl/gpio_ports.v */
// GPIO ports A and B with edge-select interrupts and AXI4-Lite registers
`timescale 1ns/1ps
`include "gpio_map.vh"
module gpio_ports (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_a_in,
  output wire [7:0] port_a_out,
  output wire [7:0] port_a_oe,
  output wire [7:0] port_a_pullup_en,
  input wire [7:0] port_b_in,
  output wire [7:0] port_b_out,
  output wire [7:0] port_b_oe,
  output wire [7:0] port_b_pullup_en,
  input wire [7:0] port_c_in,
  input wire timer_bit,
  output reg wake_event,
  output wire irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] port_a_data;
  reg [7:0] port_a_direction;
  reg [7:0] port_a_pullup;
  reg [7:0] port_b_data;
  reg [7:0] port_b_direction;
  reg [7:0] port_b_pullup;
  reg [7:0] port_a_input_enable;
  reg [7:0] port_b_input_enable;
  reg [7:0] port_c_input_enable;
  reg [4:0] interrupt_edge_select;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [3:0] group_select;

  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  wire [7:0] a_level;
  wire [7:0] b_level;
  wire [7:0] c_level;
  wire [7:0] a_gated;
  wire [7:0] b_gated;
  wire [7:0] c_gated;
  reg [7:0] a_prev;
  reg [7:0] b_prev;
  reg [7:0] c_prev;
  reg g0_prev;
  reg g1_prev;
  reg timer_prev;
  reg [2:0] irq_event;
  reg g0_pin;
  reg g1_pin;

  wire do_write;
  wire [5:0] wr_idx;
  wire [5:0] rd_idx;
  wire [7:0] wbyte;
  wire wr_hit;
  reg [7:0] next_rdata;
  reg next_rvalid_err;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function is_mapped;
    input [7:0] addr;
    reg [5:0] idx;
    begin
      idx = addr[7:2];
      case (idx)
        `IDX_EDGE_SELECT, `IDX_A_INPUT_EN, `IDX_B_INPUT_EN,
        `IDX_C_INPUT_EN, `IDX_A_DATA, `IDX_A_DIR, `IDX_A_PULLUP,
        `IDX_B_DATA, `IDX_B_DIR, `IDX_B_PULLUP, `IDX_IRQ_STATUS,
        `IDX_IRQ_MASK, `IDX_GROUP_SELECT:
          is_mapped = (addr[1:0] == 2'h0);
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Edge match for a two-bit edge-select field
  function edge_hit;
    input [1:0] mode;
    input prev;
    input now;
    begin
      case (mode)
        `EDGE_BOTH: edge_hit = prev ^ now;
        `EDGE_RISE: edge_hit = ~prev & now;
        `EDGE_FALL: edge_hit = prev & ~now;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = aw_addr[7:2];
  assign wbyte = w_data[7:0];
  assign wr_hit = do_write & w_strb[0] & is_mapped(aw_addr);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_data <= `RST_PORT;
      port_a_direction <= `RST_PORT;
      port_a_pullup <= `RST_PORT;
      port_b_data <= `RST_PORT;
      port_b_direction <= `RST_PORT;
      port_b_pullup <= `RST_PORT;
      port_a_input_enable <= `RST_INPUT_EN;
      port_b_input_enable <= `RST_INPUT_EN;
      port_c_input_enable <= `RST_INPUT_EN;
      interrupt_edge_select <= `RST_EDGE;
      irq_mask <= `RST_IRQ;
      group_select <= `RST_GROUP;
    end else if (wr_hit) begin
      case (wr_idx)
        `IDX_A_DATA: port_a_data <= wbyte;
        `IDX_A_DIR: port_a_direction <= wbyte;
        `IDX_A_PULLUP: port_a_pullup <= wbyte;
        `IDX_B_DATA: port_b_data <= wbyte;
        `IDX_B_DIR: port_b_direction <= wbyte;
        `IDX_B_PULLUP: port_b_pullup <= wbyte;
        `IDX_A_INPUT_EN: port_a_input_enable <= wbyte;
        `IDX_B_INPUT_EN: port_b_input_enable <= wbyte;
        `IDX_C_INPUT_EN: port_c_input_enable <= wbyte;
        `IDX_EDGE_SELECT: interrupt_edge_select <= wbyte[4:0];
        `IDX_IRQ_MASK: irq_mask <= wbyte[2:0];
        `IDX_GROUP_SELECT: group_select <= wbyte[3:0];
        default: port_a_data <= port_a_data;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = s_axi_araddr[7:2];

  always @* begin
    next_rvalid_err = ~is_mapped(s_axi_araddr);
    case (rd_idx)
      `IDX_A_DATA:
        next_rdata = (port_a_direction & port_a_data) |
                     (~port_a_direction & a_gated);
      `IDX_B_DATA:
        next_rdata = (port_b_direction & port_b_data) |
                     (~port_b_direction & b_gated);
      `IDX_A_DIR: next_rdata = port_a_direction;
      `IDX_A_PULLUP: next_rdata = port_a_pullup;
      `IDX_B_DIR: next_rdata = port_b_direction;
      `IDX_B_PULLUP: next_rdata = port_b_pullup;
      `IDX_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      `IDX_IRQ_MASK: next_rdata = {5'h00, irq_mask};
      `IDX_GROUP_SELECT: next_rdata = {4'h0, group_select};
      default: next_rdata = 8'h00;
    endcase
    if (next_rvalid_err)
      next_rdata = 8'h00;
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, next_rdata};
      s_axi_rresp <= next_rvalid_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_drv
      if (i == `OPEN_DRAIN_BIT) begin : g_od
        assign port_a_out[i] = 1'b0;
        assign port_a_oe[i] = port_a_direction[i] &
                              ~port_a_data[i];
      end else begin : g_pp
        assign port_a_out[i] = port_a_data[i];
        assign port_a_oe[i] = port_a_direction[i];
      end
    end
  endgenerate

  assign port_b_out = port_b_data;
  assign port_b_oe = port_b_direction;
  assign port_a_pullup_en = port_a_pullup & ~port_a_direction;
  assign port_b_pullup_en = port_b_pullup & ~port_b_direction;

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  pin_sync #(.WIDTH(8)) u_sync_a (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in(port_a_in),
    .level(a_level)
  );

  pin_sync #(.WIDTH(8)) u_sync_b (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in(port_b_in),
    .level(b_level)
  );

  pin_sync #(.WIDTH(8)) u_sync_c (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in(port_c_in),
    .level(c_level)
  );

  assign a_gated = a_level & port_a_input_enable;
  assign b_gated = b_level & port_b_input_enable;
  assign c_gated = c_level & port_c_input_enable;

  // ----------------------------------------------------------------
  // Group pin selection and edge events
  // ----------------------------------------------------------------
  always @* begin
    case (group_select[1:0])
      2'h0: g0_pin = a_gated[0];
      2'h1: g0_pin = b_gated[5];
      2'h2: g0_pin = a_gated[2];
      default: g0_pin = a_gated[7];
    endcase
    case (group_select[3:2])
      2'h0: g1_pin = b_gated[0];
      2'h1: g1_pin = a_gated[4];
      2'h2: g1_pin = a_gated[3];
      default: g1_pin = b_gated[6];
    endcase
    irq_event[`IRQ_G0] = edge_hit(
      interrupt_edge_select[`EDGE_G0_HI:`EDGE_G0_LO],
      g0_prev, g0_pin);
    irq_event[`IRQ_G1] = edge_hit(
      interrupt_edge_select[`EDGE_G1_HI:`EDGE_G1_LO],
      g1_prev, g1_pin);
    irq_event[`IRQ_TIMER] = interrupt_edge_select[`EDGE_TIMER_BIT] ?
      (timer_prev & ~timer_bit) : (~timer_prev & timer_bit);
  end

  // ----------------------------------------------------------------
  // Sticky status, wakeup
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      g0_prev <= 1'b0;
      g1_prev <= 1'b0;
      timer_prev <= 1'b0;
      a_prev <= 8'h00;
      b_prev <= 8'h00;
      c_prev <= 8'h00;
      irq_status <= `RST_IRQ;
      wake_event <= 1'b0;
    end else begin
      g0_prev <= g0_pin;
      g1_prev <= g1_pin;
      timer_prev <= timer_bit;
      a_prev <= a_level;
      b_prev <= b_level;
      c_prev <= c_level;
      if (wr_hit && wr_idx == `IDX_IRQ_STATUS)
        irq_status <= (irq_status & ~wbyte[2:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      wake_event <= |(((a_prev ^ a_level) & port_a_input_enable) |
                      ((b_prev ^ b_level) & port_b_input_enable) |
                      ((c_prev ^ c_level) & port_c_input_enable));
    end
  end

  assign irq = |(irq_status & irq_mask);
endmodule

/* File: dv/gpio_ports_assertions.sv */
// Port-level assertions for the GPIO block
`timescale 1ns/1ps
module gpio_ports_check (
  input wire ref_clk,
  input wire rst_b,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_a_out,
  input wire [7:0] port_a_oe,
  input wire [7:0] port_a_pullup_en,
  input wire [7:0] port_b_oe,
  input wire [7:0] port_b_pullup_en
);
  // ------------------------------------------------------------
  // Pin and bus properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_od_low;
    port_a_out[5] == 1'b0;
  endproperty
  property p_pu_a;
    (port_a_pullup_en & port_a_oe) == 8'h00;
  endproperty
  property p_pu_b;
    (port_b_pullup_en & port_b_oe) == 8'h00;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_lat;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_w_lat;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain pin driven high");
  a_pu_a: assert property (p_pu_a)
    else $error("port a pull-up on output pin");
  a_pu_b: assert property (p_pu_b)
    else $error("port b pull-up on output pin");
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped early");
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answer pending");
  a_w_lat: assert property (p_w_lat)
    else $error("write answer late");
endmodule
bind gpio_ports gpio_ports_check gpio_ports_check_inst (.*);

/* File: dv/pin_pad_model.sv */
// Pad model resolving the level seen on one eight-pin port
`timescale 1ns/1ps
module pin_pad_model (
  input wire ref_clk,
  input wire [7:0] out,
  input wire [7:0] oe,
  input wire [7:0] pull,
  input wire [7:0] ext_en,
  input wire [7:0] ext,
  output wire [7:0] pin
);
  reg tog = 1'b0;
  always @(posedge ref_clk) begin
    tog <= ~tog;
  end
  // Device drive, then outside driver, then pull-up, else floating
  assign pin = (oe & out) | (~oe & ext_en & ext)
    | (~oe & ~ext_en & (pull | {8{tog}}));
endmodule

/* File: dv/test_gpio_ports.sv */
// Self-checking bench for the GPIO block
`timescale 1ns/1ps
`include "gpio_map.vh"
module test_gpio_ports;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [7:0] s_axi_araddr = 8'h00;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg [7:0] ext_a = 8'h00;
  reg [7:0] ext_b = 8'h00;
  reg [7:0] ext_a_en = 8'hff;
  reg [7:0] port_c_in = 8'h00;
  reg timer_bit = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, wake_event, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_a_in, port_a_out, port_a_oe, port_a_pullup_en;
  wire [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup_en;
  integer err_count = 0;
  integer checks = 0;
  integer cyc = 0;
  integer wakes = 0;
  reg [31:0] rv;
  reg [1:0] rr;
  reg [2:0] m;
  gpio_ports gpio_ports_inst (.*);
  pin_pad_model pin_pad_model_a_inst (.ref_clk(ref_clk), .out(port_a_out),
    .oe(port_a_oe), .pull(port_a_pullup_en), .ext_en(ext_a_en),
    .ext(ext_a), .pin(port_a_in));
  pin_pad_model pin_pad_model_b_inst (.ref_clk(ref_clk), .out(port_b_out),
    .oe(port_b_oe), .pull(port_b_pullup_en), .ext_en(8'hff),
    .ext(ext_b), .pin(port_b_in));
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    if (wake_event === 1'b1) wakes = wakes + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function [7:0] ad(input [5:0] i);
    ad = {i, 2'b00};
  endfunction
  task wr(input [7:0] a, input [7:0] d);
    reg aw_t, w_t, b_t;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge ref_clk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input [7:0] a);
    reg ar_t, r_t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge ref_clk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task wt(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    chk(port_a_oe | port_b_oe, 32'h0);
    chk(port_a_pullup_en | port_b_pullup_en, 32'h0);
    rdc(ad(`IDX_A_DIR), 32'h0);
    rdc(ad(`IDX_B_DIR), 32'h0);
    rdc(ad(`IDX_A_PULLUP), 32'h0);
    rdc(ad(`IDX_B_PULLUP), 32'h0);
    rdc(ad(`IDX_EDGE_SELECT), 32'h0);
    timer_bit <= 1'b1;
    wt(2);
    rdc(ad(`IDX_IRQ_STATUS), 32'h4);
    wr(ad(`IDX_IRQ_STATUS), 8'h07);
    timer_bit <= 1'b0;
    wt(2);
    rdc(ad(`IDX_IRQ_STATUS), 32'h0);
  endtask
  task t_regs;
    wr(ad(`IDX_A_DIR), 8'hff);
    chk(port_a_out, 8'h00);
    chk(port_a_oe, 8'hff);
    wr(ad(`IDX_A_DATA), 8'h3c);
    chk(port_a_out, 8'h1c);
    chk(port_a_oe, 8'hdf);
    rdc(ad(`IDX_A_DATA), 32'h3c);
    wr(ad(`IDX_A_PULLUP), 8'hff);
    chk(port_a_pullup_en, 8'h00);
    wr(ad(`IDX_A_DIR), 8'h0f);
    chk(port_a_pullup_en, 8'hf0);
    chk(port_a_oe, 8'h0f);
    rdc(ad(`IDX_A_DIR), 32'h0f);
    rdc(ad(`IDX_A_PULLUP), 32'hff);
    wr(ad(`IDX_B_DIR), 8'ha5);
    wr(ad(`IDX_B_DATA), 8'hff);
    wr(ad(`IDX_B_PULLUP), 8'h3c);
    chk(port_b_oe, 8'ha5);
    chk(port_b_out, 8'hff);
    chk(port_b_pullup_en, 8'h18);
    rdc(ad(`IDX_B_DIR), 32'ha5);
    rdc(ad(`IDX_B_PULLUP), 32'h3c);
    wr(8'hfc, 8'h00);
    chk(rr, 2'h2);
    rd(8'hfc);
    chk(rr, 2'h2);
  endtask
  task t_read;
    ext_a <= 8'ha0;
    wt(8);
    rdc(ad(`IDX_A_DATA), 32'hac);
    ext_a <= 8'h20;
    ext_a_en <= 8'h7f;
    wt(8);
    rdc(ad(`IDX_A_DATA), 32'hac);
    wr(ad(`IDX_A_INPUT_EN), 8'h5f);
    wt(8);
    rdc(ad(`IDX_A_DATA), 32'h0c);
    rdc(ad(`IDX_A_INPUT_EN), 32'h0);
    ext_a_en <= 8'hff;
    wr(ad(`IDX_A_INPUT_EN), 8'hff);
  endtask
  task t_edge;
    wr(ad(`IDX_A_DIR), 8'h00);
    wr(ad(`IDX_B_DIR), 8'h00);
    wr(ad(`IDX_IRQ_MASK), 8'h07);
    wt(8);
    for (m = 3'd0; m < 3'd4; m = m + 3'd1) begin
      wr(ad(`IDX_EDGE_SELECT), {3'b000, m[0], m[1:0], m[1:0]});
      wr(ad(`IDX_IRQ_STATUS), 8'h07);
      ext_a[0] <= 1'b1;
      ext_b[0] <= 1'b1;
      timer_bit <= 1'b1;
      wt(8);
      rdc(ad(`IDX_IRQ_STATUS), {!m[0], !m[1], !m[1]});
      rdc(ad(`IDX_IRQ_STATUS), {!m[0], !m[1], !m[1]});
      chk(irq, !m[0] | !m[1]);
      wr(ad(`IDX_IRQ_STATUS), 8'h07);
      ext_a[0] <= 1'b0;
      ext_b[0] <= 1'b0;
      timer_bit <= 1'b0;
      wt(8);
      rdc(ad(`IDX_IRQ_STATUS), {m[0], !m[0], !m[0]});
      chk(irq, 1'b1);
    end
    wr(ad(`IDX_IRQ_STATUS), 8'h07);
    rdc(ad(`IDX_IRQ_STATUS), 32'h0);
    wr(ad(`IDX_IRQ_MASK), 8'h00);
    wr(ad(`IDX_EDGE_SELECT), 8'h00);
    ext_a[0] <= 1'b1;
    wt(8);
    chk(irq, 1'b0);
    rdc(ad(`IDX_IRQ_STATUS), 32'h1);
    wr(ad(`IDX_IRQ_MASK), 8'h01);
    chk(irq, 1'b1);
    wr(ad(`IDX_IRQ_STATUS), 8'h01);
    chk(irq, 1'b0);
    wr(ad(`IDX_GROUP_SELECT), 8'h05);
    wt(8);
    wr(ad(`IDX_IRQ_STATUS), 8'h07);
    ext_b[5] <= 1'b1;
    ext_a[4] <= 1'b1;
    wt(8);
    rdc(ad(`IDX_IRQ_STATUS), 32'h3);
    rdc(ad(`IDX_GROUP_SELECT), 32'h5);
  endtask
  task t_wake;
    wr(ad(`IDX_B_INPUT_EN), 8'h00);
    wr(ad(`IDX_C_INPUT_EN), 8'h00);
    wt(8);
    wakes = 0;
    ext_b <= ~ext_b;
    port_c_in <= ~port_c_in;
    wt(8);
    chk(wakes, 0);
    wr(ad(`IDX_C_INPUT_EN), 8'h01);
    wt(8);
    wakes = 0;
    port_c_in[0] <= ~port_c_in[0];
    wt(8);
    chk(wakes, 1);
    wr(ad(`IDX_B_INPUT_EN), 8'h80);
    wt(8);
    wakes = 0;
    ext_b[7] <= ~ext_b[7];
    wt(8);
    chk(wakes, 1);
  endtask
  task test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_regs;
    t_read;
    t_edge;
    t_wake;
    test_done;
  end
endmodule
